// ===== verilog/aoc_pkg.sv
// Package of constants and types for the amplifier offset calibration block.
package aoc_pkg;
    localparam int NUM_PHASES = 3;
    localparam int TRIM_WIDTH = 6;
    localparam int GAIN_WIDTH = 4;
    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFFS_AMP_CTRL = 8'h00;
    localparam logic [7:0] OFFS_AMP_STATUS = 8'h04;
    localparam logic [7:0] OFFS_STATUS_CLEAR = 8'h08;
    localparam logic [7:0] OFFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFFS_TRIM_U = 8'h14;
    // Field positions.
    localparam int POS_CAL_START = 0;
    localparam int POS_GAIN = 4;
    localparam int POS_BUSY = 0;
    localparam int POS_CAL_OK = 1;
    localparam int POS_IRQ_DONE = 0;
    // Values.
    localparam logic [GAIN_WIDTH-1:0] GAIN_CAL = 4'h5;
    localparam logic [GAIN_WIDTH-1:0] GAIN_RESET = 4'h0;
    localparam logic [TRIM_WIDTH-1:0] TRIM_RESET = 6'h20;
    localparam logic [TRIM_WIDTH-1:0] TRIM_MAX = 6'h3F;
    // Settling time per trim step.
    localparam int SETTLE_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SETTLE,
        PH_JUDGE
    } aoc_phase_state_type;
endpackage

// ===== verilog/aoc_phase_seq.sv
// Per-phase trim sweep engine for one current-sense amplifier.
`timescale 1ns/1ps
`default_nettype none
module aoc_phase_seq #(
    parameter int SETTLE = aoc_pkg::SETTLE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic amp_above_ref,
    output logic running,
    output logic done,
    output logic passed,
    output logic [aoc_pkg::TRIM_WIDTH-1:0] trim
);
    typedef struct packed {
        aoc_pkg::aoc_phase_state_type st;
        logic [aoc_pkg::TRIM_WIDTH-1:0] code;
        logic [aoc_pkg::TRIM_WIDTH-1:0] trim;
        logic [15:0] wait_cnt;
        logic first_above;
        logic found;
        logic done;
        logic passed;
    } aoc_seq_type;

    aoc_seq_type r;
    aoc_seq_type next_r;

    assign running = (r.st != aoc_pkg::PH_IDLE);
    assign done = r.done;
    assign passed = r.passed;
    assign trim = r.trim;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        case (r.st)
            aoc_pkg::PH_IDLE: begin
                if (start) begin
                    // The sweep starts at code zero and climbs.
                    next_r.st = aoc_pkg::PH_SETTLE;
                    next_r.code = '0;
                    next_r.trim = '0;
                    next_r.found = 1'b0;
                    next_r.passed = 1'b0;
                    next_r.wait_cnt = 16'(SETTLE);
                end
            end
            aoc_pkg::PH_SETTLE: begin
                if (r.wait_cnt > 16'h0001) begin
                    next_r.wait_cnt = r.wait_cnt - 16'h0001;
                end else if (r.code == '0) begin
                    // First sample sets the polarity a crossing must flip.
                    next_r.first_above = amp_above_ref;
                    next_r.code = r.code + 1'b1;
                    next_r.trim = r.code + 1'b1;
                    next_r.wait_cnt = 16'(SETTLE);
                end else if (amp_above_ref != r.first_above) begin
                    next_r.found = 1'b1;
                    next_r.st = aoc_pkg::PH_JUDGE;
                end else if (r.code == aoc_pkg::TRIM_MAX) begin
                    next_r.st = aoc_pkg::PH_JUDGE;
                end else begin
                    next_r.code = r.code + 1'b1;
                    next_r.trim = r.code + 1'b1;
                    next_r.wait_cnt = 16'(SETTLE);
                end
            end
            aoc_pkg::PH_JUDGE: begin
                next_r.st = aoc_pkg::PH_IDLE;
                next_r.done = 1'b1;
                next_r.passed = r.found;
                // A failed sweep must not leave a half-found trim.
                next_r.trim = r.found ? r.code : aoc_pkg::TRIM_RESET;
            end
            default: begin
                next_r.st = aoc_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= '0;
            r.trim <= aoc_pkg::TRIM_RESET;
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/aoc_top.sv
// Amplifier offset calibration sequencer with an AXI4-Lite register slave.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module aoc_top #(
    parameter int SETTLE = aoc_pkg::SETTLE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] amp_above_ref,
    output logic [3:0] amp_gain_sel,
    output logic [17:0] offset_trim_code,
    output logic irq
);
    localparam int NP = aoc_pkg::NUM_PHASES;
    localparam int TW = aoc_pkg::TRIM_WIDTH;

    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] gain_prog;
        logic [3:0] gain_out;
        logic [NP-1:0] cal_ok;
        logic [NP-1:0] start;
        logic [NP-1:0] irq_status;
        logic [NP-1:0] irq_mask;
        logic busy;
        logic [3*TW-1:0] trim_out;
        logic irq;
        logic awready;
        logic wready;
        logic arready;
    } aoc_top_type;

    aoc_top_type r;
    aoc_top_type next_r;
    logic [NP-1:0] ph_running;
    logic [NP-1:0] ph_done;
    logic [NP-1:0] ph_pass;
    logic [TW-1:0] ph_trim [NP];

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_phase
            aoc_phase_seq #(
                .SETTLE(SETTLE)
            ) u_seq (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .start(r.start[g]),
                .amp_above_ref(amp_above_ref[g]),
                .running(ph_running[g]),
                .done(ph_done[g]),
                .passed(ph_pass[g]),
                .trim(ph_trim[g])
            );
        end
    endgenerate

    function automatic logic [31:0] wmask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return (a == aoc_pkg::OFFS_AMP_CTRL) ||
            (a == aoc_pkg::OFFS_AMP_STATUS) ||
            (a == aoc_pkg::OFFS_STATUS_CLEAR) ||
            (a == aoc_pkg::OFFS_IRQ_STATUS) ||
            (a == aoc_pkg::OFFS_IRQ_MASK) ||
            (a == aoc_pkg::OFFS_TRIM_U);
    endfunction

    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign amp_gain_sel = r.gain_out;
    assign offset_trim_code = r.trim_out;
    assign irq = r.irq;

    always_comb begin
        logic [31:0] wd;
        logic [NP-1:0] ok_set;
        logic [NP-1:0] ok_clr;
        logic [NP-1:0] launch;
        logic do_write;
        wd = '0;
        ok_set = '0;
        ok_clr = '0;
        launch = '0;
        do_write = 1'b0;
        next_r = r;
        next_r.start = '0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_r.w_held = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        if (r.aw_held && r.w_held) begin
            do_write = 1'b1;
            wd = r.w_data & wmask(r.w_strb);
            next_r.aw_held = 1'b0;
            next_r.w_held = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = addr_ok(r.aw_addr) ? aoc_pkg::RESP_OKAY
                : aoc_pkg::RESP_SLVERR;
            case (r.aw_addr)
                aoc_pkg::OFFS_AMP_CTRL: begin
                    // Start bits are dropped whole while a sweep runs.
                    if (!r.busy) begin
                        launch = wd[aoc_pkg::POS_CAL_START +: NP];
                    end
                    if (r.w_strb[0]) begin
                        next_r.gain_prog = wd[aoc_pkg::POS_GAIN +: 4];
                    end
                end
                aoc_pkg::OFFS_STATUS_CLEAR: begin
                    ok_clr = wd[aoc_pkg::POS_CAL_OK +: NP];
                end
                aoc_pkg::OFFS_IRQ_STATUS: begin
                    next_r.irq_status = r.irq_status & ~wd[NP-1:0];
                end
                aoc_pkg::OFFS_IRQ_MASK: begin
                    if (r.w_strb[0]) begin
                        next_r.irq_mask = wd[NP-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        next_r.start = launch;
        for (int i = 0; i < NP; i++) begin
            if (ph_done[i] && ph_pass[i]) begin
                ok_set[i] = 1'b1;
            end
        end
        // Set beats clear; a launch zeroes the flag.
        next_r.cal_ok = ((r.cal_ok & ~ok_clr) | ok_set) & ~launch;
        // Completion events win over a simultaneous clear.
        next_r.irq_status = next_r.irq_status | ph_done;
        next_r.irq = |(next_r.irq_status & r.irq_mask);
        // Busy covers the launch cycle so no gap shows to software.
        next_r.busy = (|launch) | (|ph_running) | (|r.start);
        next_r.gain_out = next_r.busy ? aoc_pkg::GAIN_CAL : r.gain_prog;
        for (int i = 0; i < NP; i++) begin
            next_r.trim_out[i*TW +: TW] = ph_trim[i];
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = addr_ok(s_axi_araddr) ? aoc_pkg::RESP_OKAY
                : aoc_pkg::RESP_SLVERR;
            next_r.rdata = '0;
            case (s_axi_araddr)
                aoc_pkg::OFFS_AMP_CTRL: begin
                    next_r.rdata[aoc_pkg::POS_GAIN +: 4] = r.gain_prog;
                end
                aoc_pkg::OFFS_AMP_STATUS: begin
                    next_r.rdata[aoc_pkg::POS_BUSY] = r.busy;
                    next_r.rdata[aoc_pkg::POS_CAL_OK +: NP] = r.cal_ok;
                end
                aoc_pkg::OFFS_IRQ_STATUS: begin
                    next_r.rdata[NP-1:0] = r.irq_status;
                end
                aoc_pkg::OFFS_IRQ_MASK: begin
                    next_r.rdata[NP-1:0] = r.irq_mask;
                end
                aoc_pkg::OFFS_TRIM_U: begin
                    next_r.rdata[3*TW-1:0] = r.trim_out;
                end
                default: begin
                end
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (do_write && r.aw_addr == aoc_pkg::OFFS_IRQ_STATUS) begin
            next_r.irq_status = (r.irq_status & ~wd[NP-1:0]) | ph_done;
        end
        // Readies are precomputed from the next state so each leaves a flop.
        next_r.awready = ~next_r.aw_held & ~next_r.bvalid;
        next_r.wready = ~next_r.w_held & ~next_r.bvalid;
        next_r.arready = ~next_r.rvalid;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= '0;
            r.gain_prog <= aoc_pkg::GAIN_RESET;
            r.gain_out <= aoc_pkg::GAIN_RESET;
            r.trim_out <= {NP{aoc_pkg::TRIM_RESET}};
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.arready <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Gain is registered from the same busy term, so both move together.
    a_busy_gain: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        r.busy |-> amp_gain_sel == aoc_pkg::GAIN_CAL)
        else $error("Gain not forced during calibration.");
    a_launch_busy: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        |r.start |-> r.busy)
        else $error("Busy not raised on launch.");
    a_launch_clears: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        |r.start |-> (r.cal_ok & r.start) == '0)
        else $error("Pass flag not cleared at start.");
    a_busy_blocks: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $past(r.busy) && r.busy |-> r.start == '0)
        else $error("Calibration restarted while busy.");
    a_done_ok: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (ph_done[0] && ph_pass[0]) |=> r.cal_ok[0])
        else $error("Pass flag not recorded.");
    a_fail_trim: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (ph_done[1] && !ph_pass[1]) |=>
        offset_trim_code[2*TW-1:TW] == aoc_pkg::TRIM_RESET)
        else $error("Failed trim not restored.");
    a_irq_level: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        irq == |($past(next_r.irq_status) & $past(r.irq_mask)))
        else $error("Interrupt output mismatch.");
    a_idle_free: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !r.busy && !$past(r.busy) |-> ph_running == '0)
        else $error("Phase running while not busy.");
    a_clear_ok: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        r.aw_held && r.w_held && r.aw_addr == aoc_pkg::OFFS_STATUS_CLEAR &&
        r.w_strb[0] && r.w_data[aoc_pkg::POS_CAL_OK + 2] &&
        !(ph_done[2] && ph_pass[2]) |=> !r.cal_ok[2])
        else $error("Pass flag not cleared by software.");
    a_trim_keep: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !r.busy && !$past(r.busy) |-> $stable(offset_trim_code))
        else $error("Trim changed while idle.");
    a_reset_idle: assert property (
        @(posedge ref_clk)
        $past(sys_rst) && !sys_rst |-> !r.busy && r.cal_ok == '0 &&
        ph_running == '0 && offset_trim_code == {NP{aoc_pkg::TRIM_RESET}})
        else $error("Block not idle after reset.");

    c_launch_all: cover property (@(posedge ref_clk) r.start == 3'h7);
    c_pass_u: cover property (@(posedge ref_clk) ph_done[0] && ph_pass[0]);
    c_fail_v: cover property (@(posedge ref_clk) ph_done[1] && !ph_pass[1]);
    c_clear_seen: cover property (@(posedge ref_clk)
        r.aw_held && r.w_held && r.aw_addr == aoc_pkg::OFFS_STATUS_CLEAR);
    c_start_ignored: cover property (@(posedge ref_clk) r.busy &&
        r.aw_held && r.w_held && r.aw_addr == aoc_pkg::OFFS_AMP_CTRL);
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking testbench for the amplifier offset calibration block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // The comparator model answers two edges after a trim change, so the
    // settle count must cover that pipeline before each sample.
    localparam int SETTLE = 4;
    logic ref_clk;
    logic sys_rst;
    logic [7:0] s_axi_awaddr;
    logic [7:0] s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic [2:0] amp_above_ref = 3'h0;
    logic [3:0] amp_gain_sel;
    logic [17:0] offset_trim_code;
    logic irq;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    logic [15:0] lfsr = 16'hA90F;
    logic [5:0] thr [3];
    logic [2:0] fail_m = 3'h0;
    logic [2:0] exp_ok = 3'h0;
    logic [17:0] exp_tr = {3{aoc_pkg::TRIM_RESET}};
    logic [3:0] exp_gain = aoc_pkg::GAIN_RESET;
    logic [31:0] d;
    logic [1:0] r;

    aoc_top #(.SETTLE(SETTLE)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .amp_above_ref(amp_above_ref),
        .amp_gain_sel(amp_gain_sel), .offset_trim_code(offset_trim_code),
        .irq(irq));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Comparator: output rises once the code under test reaches the offset.
    // A failing phase sits above the reference at every code.
    always @(posedge ref_clk) begin
        for (int p = 0; p < 3; p++) begin
            amp_above_ref[p] <= fail_m[p] |
                (offset_trim_code[6*p+:6] >= thr[p]);
        end
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            end_of_test();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [5:0] exp_trim(input int p);
        return fail_m[p] ? aoc_pkg::TRIM_RESET : thr[p];
    endfunction

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Both halves are offered together; each is dropped once it is taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (aw_ok && w_ok && s_axi_bvalid) break;
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
        logic ar_ok;
        ar_ok = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (ar_ok && s_axi_rvalid) break;
            if (!ar_ok && s_axi_arready) begin
                ar_ok = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic launch(input logic [2:0] st, input logic [3:0] g);
        axi_wr(aoc_pkg::OFFS_AMP_CTRL, {24'h0, g, 1'b0, st}, r);
        repeat (2) @(posedge ref_clk);
        chk("gain", {28'h0, amp_gain_sel}, {28'h0, aoc_pkg::GAIN_CAL});
        axi_rd(aoc_pkg::OFFS_AMP_STATUS, d, r);
        chk("start status", d, {28'h0, exp_ok & ~st, 1'b1});
        exp_gain = g;
        for (int p = 0; p < 3; p++) begin
            if (st[p]) begin
                exp_ok[p] = ~fail_m[p];
                exp_tr[6*p+:6] = exp_trim(p);
            end
        end
    endtask

    task automatic finish_run(input string name);
        int n;
        n = 0;
        do begin
            axi_rd(aoc_pkg::OFFS_AMP_STATUS, d, r);
            n++;
        end while (d[0] !== 1'b0 && n < 400);
        chk("status", d, {28'h0, exp_ok, 1'b0});
        chk("trim port", {14'h0, offset_trim_code}, {14'h0, exp_tr});
        axi_rd(aoc_pkg::OFFS_TRIM_U, d, r);
        chk("trim reg", d, {14'h0, exp_tr});
        chk("rresp", {30'h0, r}, {30'h0, aoc_pkg::RESP_OKAY});
        chk("gain", {28'h0, amp_gain_sel}, {28'h0, exp_gain});
        $display("Test %s done", name);
    endtask

    initial begin
        sys_rst = 1'b1;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        for (int p = 0; p < 3; p++) thr[p] = 6'h10;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h0);
        finish_run("reset");
        // One phase, with a start for another phase written while busy.
        lfsr = lfsr_next(lfsr);
        thr[0] = 6'h01 + (lfsr[5:0] % 6'h3E);
        axi_wr(aoc_pkg::OFFS_IRQ_MASK, 32'h0, r);
        launch(3'b001, 4'h3);
        axi_wr(aoc_pkg::OFFS_AMP_CTRL, 32'h0000_0032, r);
        finish_run("single");
        axi_rd(aoc_pkg::OFFS_IRQ_STATUS, d, r);
        chk("irq status", d, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        axi_wr(aoc_pkg::OFFS_IRQ_MASK, 32'h1, r);
        chk("irq on", {31'h0, irq}, 32'h1);
        axi_wr(aoc_pkg::OFFS_IRQ_STATUS, 32'h1, r);
        chk("irq off", {31'h0, irq}, 32'h0);
        axi_rd(aoc_pkg::OFFS_IRQ_STATUS, d, r);
        chk("irq cleared", d, 32'h0);
        // All phases together: first code, last code and a failing phase.
        thr[0] = 6'h01;
        thr[1] = 6'h2A;
        thr[2] = 6'h3F;
        fail_m = 3'b010;
        launch(3'b111, 4'h7);
        finish_run("concurrent");
        axi_wr(aoc_pkg::OFFS_STATUS_CLEAR, 32'h0000_000C, r);
        exp_ok[2] = 1'b0;
        finish_run("clear");
        // Rerun of a passed phase that now fails.
        fail_m = 3'b001;
        launch(3'b001, 4'hA);
        finish_run("rerun");
        for (int k = 0; k < 3; k++) begin
            lfsr = lfsr_next(lfsr);
            fail_m = lfsr[15:13];
            for (int p = 0; p < 3; p++) begin
                thr[p] = 6'h01 + (lfsr[5*p+:6] % 6'h3E);
            end
            launch(lfsr[12:10] | 3'b001, lfsr[9:6]);
            finish_run("random");
        end
        axi_rd(8'h40, d, r);
        chk("bad read", {r, d[29:0]}, {aoc_pkg::RESP_SLVERR, 30'h0});
        axi_wr(8'h44, 32'hFFFF_FFFF, r);
        chk("bad write", {30'h0, r}, {30'h0, aoc_pkg::RESP_SLVERR});
        $display("Test unmapped done");
        end_of_test();
    end
endmodule
`default_nettype wire
